// ===== include/psa_consts.svh
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH

`define PSA_OFF_TABLE_PAGE  8'h00
`define PSA_OFF_REMAP_PAGE  8'h04
`define PSA_OFF_CORE_CTRL   8'h08
`define PSA_OFF_FLASH_CTRL  8'h0C
`define PSA_OFF_UNLOCK_KEY  8'h10
`define PSA_OFF_STATUS      8'h14

`define PSA_CORE_REMAP_BIT  2
`define PSA_TP_CONFIG_BIT   7
`define PSA_CTL_WRITE_BIT   15
`define PSA_CTL_WRITE_ENABLE_BIT_BIT    14
`define PSA_CTL_ERR_BIT     13
`define PSA_CTL_ERASE_BIT   6

`define PSA_KEY_FIRST       8'h55
`define PSA_KEY_SECOND      8'hAA
`define PSA_OP_ROW          4'h1
`define PSA_OP_PAGE_ERASE   4'h2
`define PSA_OP_WORD         4'h3

`define PSA_ROW_ADDR_MASK   24'hFFFF80
`define PSA_PAGE_ADDR_MASK  24'hFFFC00
`define PSA_WORD_ADDR_MASK  24'hFFFFFE
`define PSA_BUF_RESET       24'hFFFFFF

`define PSA_OP_TIME_US      4000
`define PSA_CLK_MHZ         250
`define PSA_OP_CYCLES       (`PSA_OP_TIME_US * `PSA_CLK_MHZ)

`endif

// ===== include/psa_pkg.sv
package psa_pkg;
   typedef enum logic [2:0] {OP_RD_LO, OP_RD_HI, OP_WR_LO, OP_WR_HI, OP_DATA_RD} access_op_t;
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_EXTRA, ST_WRITE, ST_FINISH} seq_state_t;
   typedef enum logic [1:0] {KEY_NONE, KEY_HALF, KEY_ARMED} key_state_t;
   typedef enum logic {FL_IDLE, FL_RUN} flash_state_t;
endpackage

// ===== verilog/holding_buffer.sv
`timescale 1ns/10ps
`include "psa_consts.svh"
module holding_buffer
   import psa_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        we_lo,
   input  wire logic        we_hi,
   input  wire logic        byte_mode,
   input  wire logic        byte_sel,
   input  wire logic [5:0]  idx,
   input  wire logic [15:0] wdata,
   input  wire logic        clear_count,
   input  wire logic [5:0]  rd_idx,
   output logic      [23:0] rd_data,
   output logic      [6:0]  load_count
);
   logic [23:0] entry_r [64];

   genvar g;
   generate
      for (g = 0; g < 64; g++) begin : g_entry
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               entry_r[g] <= `PSA_BUF_RESET;
            end else if (idx == 6'(g)) begin
               if (we_lo && (!byte_mode || !byte_sel)) entry_r[g][7:0] <= wdata[7:0];
               if (we_lo && !byte_mode) entry_r[g][15:8] <= wdata[15:8];
               if (we_lo && byte_mode && byte_sel) entry_r[g][15:8] <= wdata[7:0];
               // A byte write aimed at the phantom byte is dropped.
               if (we_hi && (!byte_mode || !byte_sel)) entry_r[g][23:16] <= wdata[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_count <= 7'h00;
      end else if (clear_count) begin
         load_count <= 7'h00;
      end else if ((we_lo || we_hi) && load_count != 7'h7F) begin
         load_count <= load_count + 7'h01;
      end
   end

   assign rd_data = entry_r[rd_idx];

   logic [23:0] probe_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) probe_r <= `PSA_BUF_RESET;
      else probe_r <= entry_r[idx];
   end

   property p_lo_keeps_high;
      @(posedge hclk) disable iff (!hresetn)
      (we_lo && !we_hi) |=> (entry_r[$past(idx)][23:16] == probe_r[23:16]);
   endproperty
   a_lo_keeps_high: assert property (p_lo_keeps_high) else $error("low write changed high byte");
endmodule

// ===== verilog/flash_sequencer.sv
`timescale 1ns/10ps
`include "psa_consts.svh"
module flash_sequencer
   import psa_pkg::*;
#(
   parameter int unsigned OP_CYCLES = `PSA_OP_CYCLES
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ctl_we,
   input  wire logic        key_we,
   input  wire logic        any_we,
   input  wire logic [15:0] wdata,
   input  wire logic [23:0] tbl_addr,
   output logic      [15:0] ctl_value,
   output logic             busy,
   output logic      [23:0] flash_addr,
   output logic             start_erase,
   output logic             start_row,
   output logic             start_word
);
   key_state_t   key_r;
   flash_state_t st_r;
   logic [31:0]  timer_r;
   logic         write_enable_bit_r;
   logic         err_r;
   logic         erase_r;
   logic [3:0]   opsel_r;
   logic         go_req;
   logic         legal;
   logic         start;

   assign go_req = ctl_we && wdata[`PSA_CTL_WRITE_BIT] && (st_r == FL_IDLE);
   assign legal  = wdata[`PSA_CTL_ERASE_BIT] ? (wdata[3:0] == `PSA_OP_PAGE_ERASE) :
                   (wdata[3:0] == `PSA_OP_ROW || wdata[3:0] == `PSA_OP_WORD);
   assign start  = go_req && (key_r == KEY_ARMED) && wdata[`PSA_CTL_WRITE_ENABLE_BIT_BIT] && legal;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_r <= KEY_NONE;
      end else if (key_we) begin
         if (key_r == KEY_HALF && wdata[7:0] == `PSA_KEY_SECOND) key_r <= KEY_ARMED;
         else if (wdata[7:0] == `PSA_KEY_FIRST) key_r <= KEY_HALF;
         else key_r <= KEY_NONE;
      end else if (any_we) begin
         key_r <= KEY_NONE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         write_enable_bit_r  <= 1'b0;
         erase_r <= 1'b0;
         opsel_r <= 4'h0;
         err_r   <= 1'b0;
      end else begin
         if (ctl_we && st_r == FL_IDLE) begin
            write_enable_bit_r  <= wdata[`PSA_CTL_WRITE_ENABLE_BIT_BIT];
            erase_r <= wdata[`PSA_CTL_ERASE_BIT];
            opsel_r <= wdata[3:0];
         end
         // A refused start wins over a clear written in the same access.
         if (go_req && !start) err_r <= 1'b1;
         else if (ctl_we) err_r <= wdata[`PSA_CTL_ERR_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r    <= FL_IDLE;
         timer_r <= 32'h0000_0000;
      end else if (start) begin
         st_r    <= FL_RUN;
         timer_r <= 32'h0000_0000;
      end else if (st_r == FL_RUN) begin
         timer_r <= timer_r + 32'h0000_0001;
         if (timer_r == OP_CYCLES - 1) st_r <= FL_IDLE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flash_addr  <= 24'h000000;
         start_erase <= 1'b0;
         start_row   <= 1'b0;
         start_word  <= 1'b0;
      end else begin
         start_erase <= start && wdata[`PSA_CTL_ERASE_BIT];
         start_row   <= start && !wdata[`PSA_CTL_ERASE_BIT] && wdata[3:0] == `PSA_OP_ROW;
         start_word  <= start && !wdata[`PSA_CTL_ERASE_BIT] && wdata[3:0] == `PSA_OP_WORD;
         if (start && wdata[`PSA_CTL_ERASE_BIT]) flash_addr <= tbl_addr & `PSA_PAGE_ADDR_MASK;
         else if (start && wdata[3:0] == `PSA_OP_ROW) flash_addr <= tbl_addr & `PSA_ROW_ADDR_MASK;
         else if (start) flash_addr <= tbl_addr & `PSA_WORD_ADDR_MASK;
      end
   end

   assign busy      = (st_r == FL_RUN);
   assign ctl_value = {busy, write_enable_bit_r, err_r, 6'h00, erase_r, 2'h0, opsel_r};

   property p_start_needs_key;
      @(posedge hclk) disable iff (!hresetn)
      (start_erase || start_row || start_word) |-> ($past(key_r) == KEY_ARMED && busy);
   endproperty
   a_start_needs_key: assert property (p_start_needs_key) else $error("start without key");

   property p_run_ends;
      @(posedge hclk) disable iff (!hresetn)
      (busy && timer_r == OP_CYCLES - 1) |=> (!busy && !ctl_value[15]);
   endproperty
   a_run_ends: assert property (p_run_ends) else $error("operation did not end on time");

   property p_run_holds;
      @(posedge hclk) disable iff (!hresetn)
      (busy && timer_r < OP_CYCLES - 1) |=> busy;
   endproperty
   a_run_holds: assert property (p_run_holds) else $error("operation ended early");

   c_start_row: cover property (@(posedge hclk) disable iff (!hresetn) start_row);
endmodule

// ===== verilog/program_space_access_unit.sv
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`include "psa_consts.svh"
module program_space_access_unit
   import psa_pkg::*;
#(
   parameter int unsigned OP_CYCLES = `PSA_OP_CYCLES
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        cpu_req,
   input  wire access_op_t  cpu_op,
   input  wire logic [15:0] cpu_ea,
   input  wire logic        cpu_byte_mode,
   input  wire logic [15:0] cpu_wdata,
   input  wire logic        cpu_is_move,
   input  wire logic        cpu_in_repeat,
   input  wire logic        cpu_repeat_edge,
   output logic             cpu_done,
   output logic             cpu_busy,
   output logic      [15:0] cpu_rdata,
   output logic             cpu_data_space,
   output logic             cpu_stall,
   output logic      [23:0] pm_addr,
   output logic             pm_rd,
   output logic             pm_config_space,
   input  wire logic [23:0] pm_rdata,
   output logic      [23:0] flash_addr,
   output logic             flash_erase_page,
   output logic             flash_program_row,
   output logic             flash_program_word,
   input  wire logic [5:0]  flash_row_idx,
   output logic      [23:0] flash_row_data
);
   logic [7:0]  table_page_value_r;
   logic [7:0]  remap_page_value_r;
   logic        remap_window_enable_r;
   logic        ap_valid_r;
   logic        ap_write_r;
   logic [7:0]  ap_off_r;
   logic        ap_hit_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_mux;
   logic        wr_en;
   logic [15:0] ctl_value;
   logic        flash_busy;
   logic [6:0]  load_count;
   logic [23:0] wr_addr_r;

   seq_state_t  state_r;
   access_op_t  op_r;
   logic [15:0] ea_r;
   logic        byte_r;
   logic [15:0] wdata_r;
   logic [1:0]  extra_r;
   logic [1:0]  extra_nxt;
   logic        accept;
   logic        remap_hit;
   logic        flash_started;

   // Register bus: zero-wait AHB-Lite slave, always OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (haddr[31:8] == 24'h000000) begin
         unique case (haddr[7:0])
            `PSA_OFF_TABLE_PAGE: rd_mux = {24'h000000, table_page_value_r};
            `PSA_OFF_REMAP_PAGE: rd_mux = {24'h000000, remap_page_value_r};
            `PSA_OFF_CORE_CTRL:  rd_mux = {29'h0000_0000, remap_window_enable_r, 2'h0};
            `PSA_OFF_FLASH_CTRL: rd_mux = {16'h0000, ctl_value};
            `PSA_OFF_STATUS:     rd_mux = {23'h000000, load_count, cpu_busy, flash_busy};
            default:             rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_off_r   <= 8'h00;
         ap_hit_r   <= 1'b0;
         hrdata_r   <= 32'h0000_0000;
      end else begin
         ap_valid_r <= hsel && htrans[1] && hready;
         ap_write_r <= hwrite;
         ap_off_r   <= haddr[7:0];
         ap_hit_r   <= (haddr[31:8] == 24'h000000);
         if (hsel && htrans[1] && hready && !hwrite) hrdata_r <= rd_mux;
      end
   end

   assign wr_en = ap_valid_r && ap_write_r && ap_hit_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         table_page_value_r    <= 8'h00;
         remap_page_value_r    <= 8'h00;
         remap_window_enable_r <= 1'b0;
      end else if (wr_en) begin
         if (ap_off_r == `PSA_OFF_TABLE_PAGE) table_page_value_r <= hwdata[7:0];
         if (ap_off_r == `PSA_OFF_REMAP_PAGE) remap_page_value_r <= hwdata[7:0];
         if (ap_off_r == `PSA_OFF_CORE_CTRL) remap_window_enable_r <= hwdata[`PSA_CORE_REMAP_BIT];
      end
   end

   // Core-side sequencer: one access at a time, held off while flash runs.
   assign remap_hit = remap_window_enable_r && cpu_ea[15];
   assign accept    = (state_r == ST_IDLE) && cpu_req && !flash_busy;
   assign cpu_stall = flash_busy;
   assign cpu_done  = (state_r == ST_FINISH);
   assign cpu_busy  = (state_r != ST_IDLE);
   assign pm_rd     = (state_r == ST_FETCH);

   always_comb begin
      if (cpu_in_repeat) extra_nxt = cpu_repeat_edge ? 2'd2 : 2'd0;
      else extra_nxt = cpu_is_move ? 2'd1 : 2'd2;
   end

   function automatic logic [15:0] format_read(access_op_t op, logic bm, logic bs, logic [23:0] p);
      logic [15:0] r;
      r = 16'h0000;
      if (op == OP_RD_HI) begin
         if (!bm || !bs) r = {8'h00, p[23:16]};
      end else if (!bm) begin
         r = p[15:0];
      end else begin
         r = bs ? {8'h00, p[15:8]} : {8'h00, p[7:0]};
      end
      return r;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_IDLE;
         extra_r <= 2'd0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (accept) begin
                  extra_r <= extra_nxt;
                  if (cpu_op == OP_WR_LO || cpu_op == OP_WR_HI) state_r <= ST_WRITE;
                  else if (cpu_op == OP_DATA_RD && !remap_hit) state_r <= ST_FINISH;
                  else state_r <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (op_r == OP_DATA_RD && extra_r != 2'd0) state_r <= ST_EXTRA;
               else state_r <= ST_FINISH;
            end
            ST_EXTRA: begin
               extra_r <= extra_r - 2'd1;
               if (extra_r == 2'd1) state_r <= ST_FINISH;
            end
            ST_WRITE: state_r <= ST_FINISH;
            ST_FINISH: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_r            <= OP_RD_LO;
         ea_r            <= 16'h0000;
         byte_r          <= 1'b0;
         wdata_r         <= 16'h0000;
         pm_addr         <= 24'h000000;
         pm_config_space <= 1'b0;
         cpu_data_space  <= 1'b0;
         wr_addr_r       <= 24'h000000;
      end else if (accept) begin
         op_r           <= cpu_op;
         ea_r           <= cpu_ea;
         byte_r         <= cpu_byte_mode;
         wdata_r        <= cpu_wdata;
         cpu_data_space <= (cpu_op == OP_DATA_RD) && !remap_hit;
         if (cpu_op == OP_DATA_RD) begin
            pm_addr         <= {1'b0, remap_page_value_r, cpu_ea[14:0]};
            pm_config_space <= 1'b0;
         end else begin
            pm_addr         <= {table_page_value_r, cpu_ea};
            pm_config_space <= table_page_value_r[`PSA_TP_CONFIG_BIT];
         end
         if (cpu_op == OP_WR_LO || cpu_op == OP_WR_HI) wr_addr_r <= {table_page_value_r, cpu_ea};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cpu_rdata <= 16'h0000;
      else if (state_r == ST_FETCH) cpu_rdata <= format_read(op_r, byte_r, ea_r[0], pm_rdata);
   end

   // Buffer slot comes from address bits 6:1 since each word spans two addresses.
   holding_buffer u_buf (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .we_lo       (state_r == ST_WRITE && op_r == OP_WR_LO),
      .we_hi       (state_r == ST_WRITE && op_r == OP_WR_HI),
      .byte_mode   (byte_r),
      .byte_sel    (ea_r[0]),
      .idx         (ea_r[6:1]),
      .wdata       (wdata_r),
      .clear_count (flash_started),
      .rd_idx      (flash_row_idx),
      .rd_data     (flash_row_data),
      .load_count  (load_count)
   );

   assign flash_started = flash_erase_page || flash_program_row || flash_program_word;

   flash_sequencer #(.OP_CYCLES(OP_CYCLES)) u_seq (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .ctl_we      (wr_en && ap_off_r == `PSA_OFF_FLASH_CTRL),
      .key_we      (wr_en && ap_off_r == `PSA_OFF_UNLOCK_KEY),
      .any_we      (wr_en),
      .wdata       (hwdata[15:0]),
      .tbl_addr    (wr_addr_r),
      .ctl_value   (ctl_value),
      .busy        (flash_busy),
      .flash_addr  (flash_addr),
      .start_erase (flash_erase_page),
      .start_row   (flash_program_row),
      .start_word  (flash_program_word)
   );

   property p_table_addr;
      @(posedge hclk) disable iff (!hresetn)
      (accept && cpu_op inside {OP_RD_LO, OP_RD_HI}) |=>
         (pm_rd && pm_addr == {$past(table_page_value_r), $past(cpu_ea)}
          && pm_config_space == pm_addr[23]);
   endproperty
   a_table_addr: assert property (p_table_addr) else $error("table address wrong");

   property p_remap_addr;
      @(posedge hclk) disable iff (!hresetn)
      (pm_rd && op_r == OP_DATA_RD) |-> (pm_addr[23] == 1'b0 && pm_addr[15] == remap_page_value_r[0]
                                         && pm_addr[14:0] == ea_r[14:0]);
   endproperty
   a_remap_addr: assert property (p_remap_addr) else $error("remap address wrong");

   property p_high_word;
      @(posedge hclk) disable iff (!hresetn)
      (pm_rd && op_r == OP_RD_HI && !byte_r) |=> (cpu_done && cpu_rdata == {8'h00, $past(pm_rdata[23:16])});
   endproperty
   a_high_word: assert property (p_high_word) else $error("high word read wrong");

   property p_phantom;
      @(posedge hclk) disable iff (!hresetn)
      (pm_rd && op_r == OP_RD_HI && byte_r && ea_r[0]) |=> (cpu_rdata == 16'h0000);
   endproperty
   a_phantom: assert property (p_phantom) else $error("phantom byte not zero");

   property p_low_byte;
      @(posedge hclk) disable iff (!hresetn)
      (pm_rd && op_r == OP_RD_LO && byte_r) |=>
         (cpu_rdata[7:0] == ($past(ea_r[0]) ? $past(pm_rdata[15:8]) : $past(pm_rdata[7:0])));
   endproperty
   a_low_byte: assert property (p_low_byte) else $error("low byte select wrong");

   property p_move_remap;
      @(posedge hclk) disable iff (!hresetn)
      (accept && cpu_op == OP_DATA_RD && remap_hit && !cpu_in_repeat && cpu_is_move) |-> ##3 cpu_done;
   endproperty
   a_move_remap: assert property (p_move_remap) else $error("move remap timing wrong");

   property p_other_remap;
      @(posedge hclk) disable iff (!hresetn)
      (accept && cpu_op == OP_DATA_RD && remap_hit && (cpu_in_repeat ? cpu_repeat_edge : !cpu_is_move))
         |-> !cpu_done [*4] ##1 cpu_done;
   endproperty
   a_other_remap: assert property (p_other_remap) else $error("two-cycle remap timing wrong");

   property p_repeat_fast;
      @(posedge hclk) disable iff (!hresetn)
      (accept && cpu_op == OP_DATA_RD && remap_hit && cpu_in_repeat && !cpu_repeat_edge) |-> ##2 cpu_done;
   endproperty
   a_repeat_fast: assert property (p_repeat_fast) else $error("repeat middle timing wrong");

   property p_write_two;
      @(posedge hclk) disable iff (!hresetn)
      (accept && cpu_op inside {OP_WR_LO, OP_WR_HI}) |-> ##1 (!pm_rd && !flash_started) ##1 cpu_done;
   endproperty
   a_write_two: assert property (p_write_two) else $error("table write timing wrong");

   property p_no_fetch_in_flash;
      @(posedge hclk) disable iff (!hresetn)
      flash_busy |-> !accept;
   endproperty
   a_no_fetch_in_flash: assert property (p_no_fetch_in_flash) else $error("access during flash op");

   c_remap_move: cover property (@(posedge hclk) disable iff (!hresetn) accept && remap_hit && cpu_is_move);
   c_table_write: cover property (@(posedge hclk) disable iff (!hresetn) accept && cpu_op == OP_WR_HI);
   c_config_read: cover property (@(posedge hclk) disable iff (!hresetn) pm_rd && pm_config_space);
endmodule

// ===== testbench/prog_mem_model.sv
`timescale 1ns/10ps
module prog_mem_model (
   input  wire logic [23:0] pm_addr,
   input  wire logic        pm_rd,
   output logic      [23:0] pm_rdata
);
   assign pm_rdata = {24{~pm_rd}} ^ {{8{pm_addr[0]}}, pm_addr[15:0] ^ pm_addr[23:8]};
endmodule

// ===== testbench/program_space_access_unit_test.sv
`timescale 1ns/10ps
module program_space_access_unit_test import psa_pkg::*; ;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cpu_req = 0, bm = 0, mv = 0, rpt = 0, redge = 0;
   wire logic hreadyout, hresp, done, busy, dsp, stall, pm_rd, pm_cfg, fe, fr, fw;
   logic [31:0] haddr = 0, hwdata = 0, r, x, hrdata;
   logic [1:0] htrans = 0;
   logic [15:0] ea = 0, wd = 0, rdata;
   access_op_t op = OP_RD_LO;
   logic [23:0] a, pm_addr, pm_rdata, faddr, frd;
   int n_errors = 0, cmp_count = 0, seed = 4, n, starts = 0;
   program_space_access_unit #(.OP_CYCLES(20)) u_program_space_access_unit (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cpu_req,
      .cpu_op(op), .cpu_ea(ea), .cpu_byte_mode(bm), .cpu_wdata(wd), .cpu_is_move(mv), .cpu_in_repeat(rpt),
      .cpu_repeat_edge(redge), .cpu_done(done), .cpu_busy(busy), .cpu_rdata(rdata), .cpu_data_space(dsp),
      .cpu_stall(stall), .pm_addr, .pm_rd, .pm_config_space(pm_cfg), .pm_rdata, .flash_addr(faddr),
      .flash_erase_page(fe), .flash_program_row(fr), .flash_program_word(fw), .flash_row_idx(ea[6:1]),
      .flash_row_data(frd));
   prog_mem_model u_prog_mem_model (.pm_addr, .pm_rd, .pm_rdata);
   always #2 hclk = ~hclk;
   always @(posedge hclk) if (fr) starts++;
   always @(negedge hclk) if (pm_rd) a = pm_addr;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) n_errors++;
      if (got !== exp) $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
   endtask
   task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      @(posedge hclk) {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, 24'h0, ad, wr};
      do @(posedge hclk); while (!hreadyout);
      {htrans, hwdata} <= {2'h0, d};
      do @(posedge hclk); while (!hreadyout);
      r = hrdata;
   endtask
   task automatic core(input access_op_t o, input logic [15:0] e, input logic b, m, p, g);
      @(posedge hclk) op <= o;
      {ea, bm, mv, rpt, redge, cpu_req} <= {e, b, m, p, g, 1'b1};
      for (n = 0; !done && n < 50; n++) @(negedge hclk);
      @(posedge hclk) cpu_req <= 0;
   endtask
   function automatic logic [15:0] exp_rd(input logic hi, b, s, input logic [23:0] v);
      return hi ? ((b && s) ? 16'h0 : {8'h0, v[23:16]}) : b ? {8'h0, s ? v[15:8] : v[7:0]} : v[15:0];
   endfunction
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1;
      ahb(0, 8'h40, 0);
      chk(r, 0);
      for (int i = 0; i < 16; i++) begin
         x = $random(seed);
         ahb(1, 8'h00, {24'h0, x[23:16]});
         core(i[1] ? OP_RD_HI : OP_RD_LO, x[15:0], i[0], 0, 0, 0);
         chk(a, x[23:0]);
         chk(pm_cfg, x[23]);
         chk(n, 3);
         chk(rdata, exp_rd(i[1], i[0], x[0], {{8{x[0]}}, x[15:0] ^ x[23:8]}));
      end
      ahb(1, 8'h04, 32'h35);
      ahb(1, 8'h08, 32'h4);
      for (int i = 0; i < 5; i++) begin
         x = $random(seed);
         core(OP_DATA_RD, {i < 4, x[14:0]}, 0, i == 0, i > 1, i == 3);
         chk(n, i == 4 ? 2 : i == 2 ? 3 : i == 0 ? 4 : 5);
         if (i < 4) chk(a, {9'h035, x[14:0]});
         if (i < 4) chk(rdata, {1'b1, x[14:0]} ^ {8'h35, x[14:8]});
         chk(dsp, i == 4);
      end
      ahb(1, 8'h00, 0);
      for (int k = 0; k < 64; k++) begin
         wd <= 16'(k);
         core(OP_WR_LO, 16'h6000 + 16'(2 * k), 0, 0, 0, 0);
         chk(n, 3);
         core(OP_WR_HI, ea, 0, 0, 0, 0);
      end
      chk(frd, 24'h3F003F);
      for (int j = 0; j < 3; j++) begin
         if (j > 0) ahb(1, 8'h10, 32'h55);
         if (j > 0) ahb(1, 8'h10, 32'hAA);
         ahb(1, 8'h0C, 32'hC001);
         repeat (3) @(negedge hclk);
         chk(starts, j);
         chk(stall, j > 0);
         chk(faddr, j > 0 ? 24'h006000 : 24'h0);
         repeat (30) @(negedge hclk);
         ahb(0, 8'h0C, 0);
         chk(r[15:13], j > 0 ? 3'h2 : 3'h3);
      end
      report_and_stop;
   end
   initial begin
      #100000 n_errors++;
      report_and_stop;
   end
endmodule
